// ==== logic/vout_fault_params.svh ====
// Constants for the output-voltage fault response logic
`ifndef VOUT_FAULT_PARAMS_SVH
`define VOUT_FAULT_PARAMS_SVH
`define UV_RESP_RESET       8'hB8
`define OV_RESP_RESET       8'h80
`define RESP_ACTION_MSB     7
`define RESP_ACTION_LSB     6
`define RESP_RETRY_MSB      5
`define RESP_RETRY_LSB      3
`define RESP_DELAY_MSB      2
`define RESP_DELAY_LSB      0
`define RETRY_ENDLESS       3'h7
`define STEP_TIME_NS        10000
`define CLK_PERIOD_NS       25
`define STEP_CYCLES         (`STEP_TIME_NS / `CLK_PERIOD_NS)
`define RETRY_MS_RESET      16'h015E
`define CYCLES_PER_MS       40000
`define VOUT_UV_BIT         4
`define VOUT_OV_BIT         7
`define WORD_VOUT_BIT       15
`endif

// ==== logic/vout_fault_pkg.sv ====
// Types for the output-voltage fault response logic
package vout_fault_pkg;
  typedef enum logic [1:0] {
    ACT_CONTINUE = 2'h0,
    ACT_DELAYED  = 2'h1,
    ACT_NOW      = 2'h2,
    ACT_BAD      = 2'h3
  } action_t;
  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_WAIT  = 2'h1,
    ST_OFF   = 2'h3,
    ST_RETRY = 2'h2
  } resp_state_t;
endpackage : vout_fault_pkg

// ==== logic/vout_fault_response_logic.sv ====
// Output under/overvoltage fault response, status and alert logic
`timescale 1ns/1ps
`default_nettype none
`include "vout_fault_params.svh"
// Operation
// - Undervoltage fault sets the output-voltage summary bit of status word.
// - Undervoltage fault sets the undervoltage bit of output-voltage status.
// - Output-voltage fault raises alert unless its source is masked.
// - Undervoltage response setting is a single data byte.
// - Status bits set on fault whatever response field is chosen.
// - Response 00 keeps running forever, hardware reaction only.
// - Response 01 runs for delay; lasting fault disables, then retry field.
// - Response 10 disables at once, then follows retry field.
// - Writing response 11 is refused and flags a communication fault.
// - Latched faults clear by clear, off-on, restore, vendor reset, power.
// - Writing one to an output-voltage status bit clears that fault.
// - Retry 000-110: no restart; stays off until cleared or off-on.
// - Retry 111: endless restarts spaced by retry interval.
// - Retrying stops on off command, power loss, or forced shutdown.
// - Delay field counts persistence in 10 us steps.
// - Hardware reaction still applies during persistence delay.
// - Overvoltage setting shares layout and meaning with undervoltage.
// - Retry interval in ms, default 350 ms.
// - Overvoltage setting is read-only, one byte.
module vout_fault_response_logic #(
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        uv_detect_i,
  input  wire logic        ov_detect_i,
  input  wire logic        uv_mask_i,
  input  wire logic        ov_mask_i,
  input  wire logic        run_cmd_i,
  input  wire logic        clear_faults_i,
  input  wire logic        restore_user_all_i,
  input  wire logic        vendor_soft_reset_command_i,
  input  wire logic        forced_shutdown_i,
  input  wire logic        uv_resp_wr_i,
  input  wire logic [7:0]  uv_resp_data_i,
  input  wire logic        retry_wr_i,
  input  wire logic [15:0] retry_interval_setting_i,
  input  wire logic        status_vout_wr_i,
  input  wire logic [7:0]  status_vout_data_i,
  output logic [7:0]       undervoltage_response_setting_o,
  output logic [7:0]       overvoltage_response_setting_o,
  output logic [7:0]       status_vout_o,
  output logic [15:0]      status_word_o,
  output logic             cml_fault_o,
  output logic             alert_o,
  output logic             output_enable_o,
  output logic             hw_reaction_o
);
  import vout_fault_pkg::*;

  // ************************************************************
  // Settings and status
  // ************************************************************
  logic [7:0]  uv_resp;
  logic [7:0]  next_uv_resp;
  logic [15:0] retry_ms;
  logic [15:0] next_retry_ms;
  logic        uv_flag;
  logic        next_uv_flag;
  logic        ov_flag;
  logic        next_ov_flag;
  logic        cml;
  logic        next_cml;
  logic        run_q;
  logic        clear_all;
  logic        off_on;

  assign off_on    = run_cmd_i & ~run_q;
  // Off-then-on seen as run rising edge
  assign clear_all = clear_faults_i | restore_user_all_i
                   | vendor_soft_reset_command_i | off_on;

  always_comb begin
    next_uv_resp  = uv_resp;
    next_retry_ms = retry_ms;
    next_cml      = cml & ~clear_all;
    if (uv_resp_wr_i) begin
      if (uv_resp_data_i[`RESP_ACTION_MSB:`RESP_ACTION_LSB] == ACT_BAD) begin
        next_cml = 1'b1;
      end else begin
        next_uv_resp = uv_resp_data_i;
      end
    end
    if (retry_wr_i) begin
      next_retry_ms = retry_interval_setting_i;
    end
    // Set wins over clear for both flags
    next_uv_flag = uv_flag;
    next_ov_flag = ov_flag;
    if (clear_all) begin
      next_uv_flag = 1'b0;
      next_ov_flag = 1'b0;
    end
    if (status_vout_wr_i && status_vout_data_i[`VOUT_UV_BIT]) begin
      next_uv_flag = 1'b0;
    end
    if (status_vout_wr_i && status_vout_data_i[`VOUT_OV_BIT]) begin
      next_ov_flag = 1'b0;
    end
    if (uv_detect_i) begin
      next_uv_flag = 1'b1;
    end
    if (ov_detect_i) begin
      next_ov_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      uv_resp  <= `UV_RESP_RESET;
      retry_ms <= `RETRY_MS_RESET;
      uv_flag  <= 1'b0;
      ov_flag  <= 1'b0;
      cml      <= 1'b0;
      run_q    <= 1'b0;
    end else if (clk_en_i) begin
      uv_resp  <= next_uv_resp;
      retry_ms <= next_retry_ms;
      uv_flag  <= next_uv_flag;
      ov_flag  <= next_ov_flag;
      cml      <= next_cml;
      run_q    <= run_cmd_i;
    end
  end

  // Overvoltage setting is fixed: no write path exists
  assign overvoltage_response_setting_o = `OV_RESP_RESET;
  assign undervoltage_response_setting_o = uv_resp;
  assign status_vout_o = {ov_flag, 2'h0, uv_flag, 4'h0};
  assign status_word_o = {uv_flag | ov_flag, 15'h0};
  assign cml_fault_o   = cml;
  assign alert_o = (uv_flag & ~uv_mask_i) | (ov_flag & ~ov_mask_i);

  // ************************************************************
  // Response sequencer
  // ************************************************************
  // Overvoltage takes priority; it uses the same field decode
  logic        sel_ov;
  logic        fault_now;
  logic [7:0]  resp;
  action_t     act;
  logic [2:0]  retry_f;
  resp_state_t state;
  resp_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [31:0] delay_cycles;
  logic [31:0] retry_cycles;
  logic        off_ov;
  logic        next_off_ov;
  localparam logic [7:0] OV_RESP = `OV_RESP_RESET;

  assign sel_ov    = ov_detect_i;
  assign fault_now = uv_detect_i | ov_detect_i;
  assign resp      = sel_ov ? `OV_RESP_RESET : uv_resp;
  assign act       = action_t'(resp[`RESP_ACTION_MSB:`RESP_ACTION_LSB]);
  // Retry follows the fault that caused the shutdown, not the live one
  assign retry_f   = off_ov ? OV_RESP[`RESP_RETRY_MSB:`RESP_RETRY_LSB]
                            : uv_resp[`RESP_RETRY_MSB:`RESP_RETRY_LSB];
  assign delay_cycles = 32'(resp[`RESP_DELAY_MSB:`RESP_DELAY_LSB])
                      * 32'(`STEP_CYCLES);
  assign retry_cycles = 32'(retry_ms) * 32'(CYCLES_PER_MS);
  // Fixed reaction runs regardless of programmed action
  assign hw_reaction_o = fault_now;

  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_off_ov = off_ov;
    case (state)
      ST_RUN: begin
        next_cnt = 32'h0;
        if (fault_now && act == ACT_NOW) begin
          next_state  = ST_OFF;
          next_off_ov = sel_ov;
        end else if (fault_now && act == ACT_DELAYED) begin
          next_state = ST_WAIT;
          next_cnt   = 32'h1;
        end
      end
      ST_WAIT: begin
        if (!fault_now || act != ACT_DELAYED) begin
          next_state = ST_RUN;
          next_cnt   = 32'h0;
        end else if (cnt >= delay_cycles) begin
          next_state  = ST_OFF;
          next_cnt    = 32'h0;
          next_off_ov = 1'b0;
        end else begin
          next_cnt = cnt + 32'h1;
        end
      end
      ST_OFF: begin
        next_cnt = 32'h0;
        if (off_on || clear_all) begin
          next_state = ST_RUN;
        end else if (retry_f == `RETRY_ENDLESS && !forced_shutdown_i
                     && run_cmd_i) begin
          next_state = ST_RETRY;
        end
      end
      ST_RETRY: begin
        if (!run_cmd_i || forced_shutdown_i) begin
          next_state = ST_OFF;
          next_cnt   = 32'h0;
        end else if (cnt + 32'h1 >= retry_cycles) begin
          next_state = ST_RUN;
          next_cnt   = 32'h0;
        end else begin
          next_cnt = cnt + 32'h1;
        end
      end
      default: begin
        next_state = ST_RUN;
        next_cnt   = 32'h0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state  <= ST_RUN;
      cnt    <= 32'h0;
      off_ov <= 1'b0;
    end else if (clk_en_i) begin
      state  <= next_state;
      cnt    <= next_cnt;
      off_ov <= next_off_ov;
    end
  end

  assign output_enable_o = run_cmd_i && (state == ST_RUN || state == ST_WAIT);

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_bad_write;
    clk_en_i && uv_resp_wr_i && uv_resp_data_i[7:6] == 2'h3;
  endsequence
  property p_uv_flag;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && uv_detect_i |=> uv_flag && status_word_o[15];
  endproperty
  a_uv_flag: assert property (p_uv_flag)
    else $error("uv flag missing");
  property p_uv_bit;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && uv_detect_i |=> status_vout_o[4];
  endproperty
  a_uv_bit: assert property (p_uv_bit) else $error("uv bit missing");
  property p_alert;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      uv_flag && !uv_mask_i |-> alert_o;
  endproperty
  a_alert: assert property (p_alert) else $error("alert missing");
  property p_bad;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      s_bad_write |=> cml_fault_o && $stable(uv_resp);
  endproperty
  a_bad: assert property (p_bad) else $error("bad write taken");
  property p_now;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && state == ST_RUN && fault_now && act == ACT_NOW
      |=> state == ST_OFF;
  endproperty
  a_now: assert property (p_now) else $error("no immediate off");
  property p_w1c;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && status_vout_wr_i && status_vout_data_i[4] && !uv_detect_i
      |=> !uv_flag;
  endproperty
  a_w1c: assert property (p_w1c) else $error("w1c failed");
  property p_ovro;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      overvoltage_response_setting_o == 8'h80;
  endproperty
  a_ovro: assert property (p_ovro) else $error("ov setting changed");
  property p_retry_stop;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && state == ST_RETRY && forced_shutdown_i |=> state == ST_OFF;
  endproperty
  a_retry_stop: assert property (p_retry_stop)
    else $error("retry kept");
  property p_wait_reset;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && state == ST_WAIT && !fault_now
      |=> state == ST_RUN && cnt == 0;
  endproperty
  a_wait_reset: assert property (p_wait_reset)
    else $error("no restart");
  // Fixed overvoltage setting never retries, whatever the other setting says
  property p_ov_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && state == ST_OFF && off_ov && !clear_all |=> state == ST_OFF;
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("ov retried");
  property p_freeze;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      !clk_en_i |=> $stable(state) && $stable(uv_flag) && $stable(uv_resp);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved when frozen");
endmodule : vout_fault_response_logic
`default_nettype wire

// ==== testbench/host_model.sv ====
// Host model that issues setting and status writes
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        core_clk_i,
  output logic             uv_wr_o,
  output logic [7:0]       uv_data_o,
  output logic             retry_wr_o,
  output logic [15:0]      retry_data_o,
  output logic             st_wr_o,
  output logic [7:0]       st_data_o
);
  // ****************
  // Write transfers
  // ****************
  initial begin
    {uv_wr_o, retry_wr_o, st_wr_o} = 3'h0;
    {uv_data_o, st_data_o} = 16'h0000;
    retry_data_o = 16'h0000;
  end
  // Sel 0 response byte, 1 retry word, 2 status byte
  task automatic put(input int sel, input logic [15:0] v);
    @(negedge core_clk_i);
    uv_data_o = v[7:0];
    retry_data_o = v;
    st_data_o = v[7:0];
    uv_wr_o = (sel == 0);
    retry_wr_o = (sel == 1);
    st_wr_o = (sel == 2);
    @(negedge core_clk_i);
    {uv_wr_o, retry_wr_o, st_wr_o} = 3'h0;
    // Released bus must not look like a held value
    uv_data_o = ~v[7:0];
    retry_data_o = ~v;
    st_data_o = ~v[7:0];
  endtask : put
endmodule : host_model
`default_nettype wire

// ==== testbench/tb_vout_fault_response_logic.sv ====
// Self-checking bench for the output-voltage fault response logic
`timescale 1ns/1ps
`default_nettype none
module tb_vout_fault_response_logic;
  localparam int CPM = 4;
  logic        clk, rst_n, uv, ov, uv_m, run, clr, uwr, rwr, swr;
  logic [7:0]  ud, sd, uset, oset, svout;
  logic [15:0] rd, sword;
  logic        cml, alert, oe, hw;
  logic        en, ovm, fsd, rua, vsr, clr_ev;
  logic        m_uv, m_ov, m_cml, m_run_q;
  logic [7:0]  m_uset;
  int          fails, comparisons, d, k, exp_st;
  logic [31:0] seed;
  // ****************
  // Harness
  // ****************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  host_model u_host (.core_clk_i(clk), .uv_wr_o(uwr), .uv_data_o(ud),
    .retry_wr_o(rwr), .retry_data_o(rd), .st_wr_o(swr), .st_data_o(sd));
  vout_fault_response_logic #(.CYCLES_PER_MS(CPM)) u_dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en),
    .uv_detect_i(uv), .ov_detect_i(ov), .uv_mask_i(uv_m),
    .ov_mask_i(ovm), .run_cmd_i(run), .clear_faults_i(clr),
    .restore_user_all_i(rua), .vendor_soft_reset_command_i(vsr),
    .forced_shutdown_i(fsd), .uv_resp_wr_i(uwr), .uv_resp_data_i(ud),
    .retry_wr_i(rwr), .retry_interval_setting_i(rd),
    .status_vout_wr_i(swr), .status_vout_data_i(sd),
    .undervoltage_response_setting_o(uset),
    .overvoltage_response_setting_o(oset), .status_vout_o(svout),
    .status_word_o(sword), .cml_fault_o(cml), .alert_o(alert),
    .output_enable_o(oe), .hw_reaction_o(hw));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Flags predicted from the bench's own fault record
  task automatic chk_flags;
    chk(16'(svout), 16'(exp_st));
    chk(sword, (exp_st != 0) ? 16'h8000 : 16'h0000);
    chk(16'(alert), 16'((exp_st[4] && !uv_m) || (exp_st[7] && !ovm)));
  endtask : chk_flags
  // Reference model of the latched bits, kept from the rules alone
  assign clr_ev = clr | rua | vsr | (run & ~m_run_q);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {m_uv, m_ov, m_cml, m_run_q} <= 4'h0;
      m_uset <= 8'hB8;
    end else if (en) begin
      m_run_q <= run;
      m_uv    <= uv | (m_uv & ~clr_ev & ~(swr & sd[4]));
      m_ov    <= ov | (m_ov & ~clr_ev & ~(swr & sd[7]));
      m_cml   <= (uwr & (ud[7:6] == 2'h3)) | (m_cml & ~clr_ev);
      if (uwr && ud[7:6] != 2'h3) begin
        m_uset <= ud;
      end
    end
  end
  // Sampled before the edge updates land, so both sides are settled
  always @(posedge clk) begin
    if (rst_n) begin
      chk({8'h00, svout}, {8'h00, m_ov, 2'h0, m_uv, 4'h0});
      chk(sword, {m_uv | m_ov, 15'h0});
      chk(16'(alert), 16'((m_uv & ~uv_m) | (m_ov & ~ovm)));
      chk(16'(cml), 16'(m_cml));
      chk(16'(uset), {8'h00, m_uset});
    end
  end
  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask : cyc
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic end_of_test;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #(25 * 20000);
    fails++;
    end_of_test();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    {rst_n, uv, ov, uv_m, clr, ovm, fsd, rua, vsr} = 9'h000;
    en = 1'b1;
    run = 1'b1;
    exp_st = 0;
    seed = 32'h5E3F;
    cyc(8);
    rst_n = 1'b1;
    cyc(1);
    chk(16'(uset), 16'h00B8);
    chk(16'(oset), 16'h0080);
    chk_flags();
    $display("test 1 done");
    u_host.put(1, 16'h0002);
    uv = 1'b1;
    exp_st = 8'h10;
    cyc(1);
    chk_flags();
    cyc(1);
    chk(16'(oe), 16'h0000);
    uv = 1'b0;
    k = 0;
    while (oe !== 1'b1 && k < 40) begin
      cyc(1);
      k++;
    end
    chk(16'(k >= 2 * CPM - 2 && k <= 2 * CPM + 4), 16'h0001);
    chk_flags();
    u_host.put(2, 16'h0010);
    exp_st = 0;
    chk_flags();
    $display("test 2 done");
    uv_m = 1'b1;
    u_host.put(0, 16'h0000);
    uv = 1'b1;
    exp_st = 8'h10;
    cyc(50);
    chk(16'(oe), 16'h0001);
    chk(16'(hw), 16'h0001);
    chk_flags();
    uv = 1'b0;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    exp_st = 0;
    cyc(1);
    chk_flags();
    u_host.put(0, 16'h00C0);
    chk(16'(cml), 16'h0001);
    chk(16'(uset), 16'h0000);
    $display("test 3 done");
    uv_m = 1'b0;
    seed = xs(seed);
    d = int'(seed % 3) + 1;
    u_host.put(0, 16'h0040 | 16'(d));
    uv = 1'b1;
    exp_st = 8'h10;
    cyc(d * 400 - 20);
    uv = 1'b0;
    cyc(2);
    uv = 1'b1;
    cyc(d * 400 - 20);
    chk(16'(oe), 16'h0001);
    cyc(25);
    chk(16'(oe), 16'h0000);
    uv = 1'b0;
    cyc(30);
    chk(16'(oe), 16'h0000);
    run = 1'b0;
    cyc(2);
    run = 1'b1;
    cyc(2);
    exp_st = 0;
    chk(16'(oe), 16'h0001);
    chk_flags();
    $display("test 4 done");
    en = 1'b0;
    uv = 1'b1;
    cyc(3);
    chk_flags();
    chk(16'(oe), 16'h0001);
    uv = 1'b0;
    en = 1'b1;
    cyc(2);
    chk_flags();
    u_host.put(0, 16'h00B8);
    ov = 1'b1;
    exp_st = 8'h80;
    cyc(1);
    chk_flags();
    chk(16'(oe), 16'h0000);
    ov = 1'b0;
    ovm = 1'b1;
    cyc(30);
    chk(16'(oe), 16'h0000);
    chk_flags();
    ovm = 1'b0;
    rua = 1'b1;
    cyc(1);
    rua = 1'b0;
    exp_st = 0;
    cyc(1);
    chk_flags();
    chk(16'(oe), 16'h0001);
    uv = 1'b1;
    cyc(1);
    uv = 1'b0;
    exp_st = 8'h10;
    cyc(3);
    fsd = 1'b1;
    cyc(20);
    chk(16'(oe), 16'h0000);
    chk_flags();
    vsr = 1'b1;
    cyc(1);
    {vsr, fsd} = 2'h0;
    exp_st = 0;
    cyc(1);
    chk_flags();
    chk(16'(oe), 16'h0001);
    $display("test 5 done");
    end_of_test();
  end
endmodule : tb_vout_fault_response_logic
`default_nettype wire
